// ---- rtl/cabbe_execute.sv ----
// Execute stage: sums, AND, shifts, bit operations and jumps
`timescale 1ns/100ps
`default_nettype none
module cabbe_execute #(
  parameter int NUM_WORK = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Instruction and operand from fetch/decode
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic [22:0] instr_pc,
  input wire logic [15:0] file_rdata,
  // Working register observation
  input wire logic [3:0] work_rd_sel,
  output logic [15:0] work_rd_data,
  // Data memory write port
  output logic file_we,
  output logic file_byte,
  output logic [12:0] file_addr,
  output logic [15:0] file_wdata,
  // Program counter redirect
  output logic pc_load,
  output logic [22:0] pc_target,
  // Status
  output logic discard,
  output logic [4:0] status_flags,
  output logic [4:0] shadow_flags
);

  // Working registers and their next values
  logic [15:0] work [NUM_WORK];
  logic [15:0] next_work [NUM_WORK];
  logic [4:0] next_flags, next_shadow;
  // Output and control next values
  logic next_file_we, next_file_byte, next_pc_load, next_discard;
  logic [12:0] next_file_addr;
  logic [15:0] next_file_wdata, next_rd_data;
  logic [22:0] next_pc_target;

  cabbe_alu_if alu_bus ();

  // Adder, AND and shifter
  cabbe_alu u_alu (
    .bus(alu_bus)
  );

  // Condition check against the current flags
  function automatic logic cond_met(input logic [3:0] cc,
      input logic [4:0] f);
    logic c, n, ov, z, r;
    c = f[cabbe_pkg::FL_C];
    n = f[cabbe_pkg::FL_N];
    ov = f[cabbe_pkg::FL_OV];
    z = f[cabbe_pkg::FL_Z];
    case (cc)
      cabbe_pkg::CC_ALWAYS: r = 1'b1;
      cabbe_pkg::CC_C: r = c;
      cabbe_pkg::CC_NC: r = !c;
      cabbe_pkg::CC_N: r = n;
      cabbe_pkg::CC_NN: r = !n;
      cabbe_pkg::CC_OV: r = ov;
      cabbe_pkg::CC_NOV: r = !ov;
      cabbe_pkg::CC_Z: r = z;
      cabbe_pkg::CC_NZ: r = !z;
      cabbe_pkg::CC_GT: r = !z && (n == ov);
      cabbe_pkg::CC_GE: r = (n == ov);
      cabbe_pkg::CC_LT: r = (n != ov);
      cabbe_pkg::CC_LE: r = z || (n != ov);
      cabbe_pkg::CC_GTU: r = c && !z;
      cabbe_pkg::CC_LEU: r = !c || z;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Field decode; the opcode is the top byte of the word
  logic [7:0] opc;
  logic [6:0] op7;
  logic [1:0] grp, form, kind;
  logic [3:0] base_sel, src_sel, dst_sel, bit_pos, flag_pos;
  logic [4:0] five_bit_literal;
  logic [9:0] ten_bit_literal;
  logic bm, exec, dest_file;
  assign opc = instr_word[cabbe_pkg::OPC_LSB +: 8];
  assign op7 = opc[6:0];
  assign grp = op7[3:2];
  assign form = op7[1:0];
  assign kind = op7[2:1];
  // Double-word selects decode as word; only byte narrows
  assign bm = instr_word[cabbe_pkg::SIZE_LSB +: 2] ==
    cabbe_pkg::SZ_BYTE;
  assign dest_file = instr_word[cabbe_pkg::DEST_BIT];
  assign base_sel = instr_word[cabbe_pkg::BASE_LSB +: 4];
  assign src_sel = instr_word[cabbe_pkg::SRC_LSB +: 4];
  assign five_bit_literal = instr_word[cabbe_pkg::SRC_LSB +: 5];
  assign ten_bit_literal = instr_word[cabbe_pkg::L10_LSB +: 10];
  assign dst_sel = instr_word[3:0];
  assign bit_pos = instr_word[cabbe_pkg::BITPOS_LSB +: 4];
  assign flag_pos = work[base_sel][3:0];
  // A word that lands while discarding is dropped
  assign exec = instr_valid && !discard;

  // Instruction classes
  logic is_arith, is_bit, is_bit_w, is_flag_wr, is_jump, is_jump_reg;
  assign is_arith = (op7[6:4] == cabbe_pkg::FAM_ARITH) &&
    (form != 2'h0);
  assign is_bit = op7[6:3] == cabbe_pkg::FAM_BIT;
  assign is_bit_w = is_bit && op7[0];
  assign is_flag_wr = op7 == cabbe_pkg::OP_FLAG_WR;
  assign is_jump = op7[6:4] == cabbe_pkg::FAM_JUMP;
  assign is_jump_reg = op7 == cabbe_pkg::OP_JUMP_REG;

  // Operand routing into the adder/shifter
  always_comb begin
    alu_bus.byte_mode = bm;
    alu_bus.cin = (grp == cabbe_pkg::GRP_SUMC) &&
      status_flags[cabbe_pkg::FL_C];
    alu_bus.count = five_bit_literal;
    alu_bus.b = 16'h0000;
    case (form)
      cabbe_pkg::FORM_F: begin
        // File form pairs the file word with register 0
        alu_bus.a = file_rdata;
        alu_bus.b = work[0];
      end
      cabbe_pkg::FORM_L10: begin
        // Single shift here means source into destination
        alu_bus.a = (grp == cabbe_pkg::GRP_SHIFT) ? work[src_sel] :
          work[dst_sel];
        alu_bus.b = bm ? {8'h00, ten_bit_literal[7:0]} : {6'h00, ten_bit_literal};
      end
      default: begin
        alu_bus.a = work[base_sel];
        alu_bus.b = instr_word[cabbe_pkg::LITSEL_BIT] ?
          {11'h000, five_bit_literal} : work[src_sel];
        if (!instr_word[cabbe_pkg::LITSEL_BIT]) begin
          alu_bus.count = {1'b0, work[src_sel][3:0]};
        end
      end
    endcase
    case (grp)
      cabbe_pkg::GRP_AND: alu_bus.op = cabbe_pkg::ALU_AND;
      cabbe_pkg::GRP_SHIFT: alu_bus.op = (form == cabbe_pkg::FORM_REG) ?
        cabbe_pkg::ALU_SHRN : cabbe_pkg::ALU_SHR1;
      default: alu_bus.op = cabbe_pkg::ALU_SUM;
    endcase
  end

  // Bit operation target and result
  logic [15:0] bit_val, bit_mask, bit_res;
  logic bit_clear, skip_now, jump_taken;
  assign bit_val = is_bit_w ? work[dst_sel] : file_rdata;
  assign bit_mask = 16'h0001 << bit_pos;
  assign bit_clear = !bit_val[bit_pos];
  always_comb begin
    case (kind)
      cabbe_pkg::BK_SET: bit_res = bit_val | bit_mask;
      cabbe_pkg::BK_CLR: bit_res = bit_val & ~bit_mask;
      cabbe_pkg::BK_TOG: bit_res = bit_val ^ bit_mask;
      default: bit_res = bit_val;
    endcase
  end
  assign skip_now = is_bit && (kind == cabbe_pkg::BK_TSC) && bit_clear;
  assign jump_taken = (is_jump && cond_met(op7[3:0], status_flags)) ||
    is_jump_reg;

  // Register file, flags and shadow next values
  always_comb begin
    logic [3:0] di;
    logic [15:0] wr;
    di = (form == cabbe_pkg::FORM_F) ? 4'h0 : dst_sel;
    wr = bm ? {work[di][15:8], alu_bus.res[7:0]} : alu_bus.res;
    next_work = work;
    next_flags = status_flags;
    next_shadow = shadow_flags;
    if (exec) begin
      if (is_arith) begin
        // Result lands in a register unless the file is chosen
        if (!(form == cabbe_pkg::FORM_F && dest_file)) begin
          next_work[di] = wr;
        end
        next_flags[cabbe_pkg::FL_N] = alu_bus.n;
        if (grp == cabbe_pkg::GRP_SUMC) begin
          // Zero may only fall, so multi-word zero tests hold
          next_flags[cabbe_pkg::FL_Z] = status_flags[cabbe_pkg::FL_Z] &&
            alu_bus.z;
        end else begin
          next_flags[cabbe_pkg::FL_Z] = alu_bus.z;
        end
        if (grp == cabbe_pkg::GRP_SUM || grp == cabbe_pkg::GRP_SUMC) begin
          next_flags[cabbe_pkg::FL_C] = alu_bus.c;
          next_flags[cabbe_pkg::FL_DC] = alu_bus.dc;
          next_flags[cabbe_pkg::FL_OV] = alu_bus.ov;
        end else if (grp == cabbe_pkg::GRP_SHIFT &&
            form != cabbe_pkg::FORM_REG) begin
          next_flags[cabbe_pkg::FL_C] = alu_bus.c;
          next_flags[cabbe_pkg::FL_OV] = alu_bus.ov;
        end
      end
      // Bit ops on registers write back, flags untouched
      if (is_bit_w && kind != cabbe_pkg::BK_TSC) begin
        next_work[dst_sel] = bit_res;
      end
      if (is_flag_wr) begin
        next_work[src_sel][flag_pos] =
          instr_word[cabbe_pkg::FLAGSEL_BIT] ?
          status_flags[cabbe_pkg::FL_Z] :
          status_flags[cabbe_pkg::FL_C];
      end
      // Shadow select snapshots the flags after the operation
      if (opc[cabbe_pkg::SHADOW_BIT]) begin
        next_shadow = next_flags;
      end
    end
  end

  // Register file, flags and shadow
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_WORK; i++) begin
        work[i] <= cabbe_pkg::WORK_RST;
      end
      status_flags <= cabbe_pkg::FLAGS_RST;
      shadow_flags <= cabbe_pkg::FLAGS_RST;
    end else begin
      work <= next_work;
      status_flags <= next_flags;
      shadow_flags <= next_shadow;
    end
  end

  // Memory write, redirect and discard next values
  always_comb begin
    logic [22:0] rel;
    rel = instr_pc + 23'h000002;
    next_file_we = 1'b0;
    next_file_byte = file_byte;
    next_file_addr = file_addr;
    next_file_wdata = file_wdata;
    next_pc_load = 1'b0;
    next_pc_target = pc_target;
    next_rd_data = work[work_rd_sel];
    // Discard lasts until the following word has arrived
    next_discard = instr_valid ? 1'b0 : discard;
    if (exec) begin
      if (is_arith && form == cabbe_pkg::FORM_F && dest_file) begin
        next_file_we = 1'b1;
        next_file_byte = bm;
        next_file_addr = instr_word[cabbe_pkg::FADDR_W - 1:0];
        next_file_wdata = alu_bus.res;
      end
      if (is_bit && !op7[0] && kind != cabbe_pkg::BK_TSC) begin
        // Bit forms address whole words, so bit 0 is zero
        next_file_we = 1'b1;
        next_file_byte = 1'b0;
        next_file_addr = {instr_word[11:0], 1'b0};
        next_file_wdata = bit_res;
      end
      if (skip_now) begin
        // The next word is thrown away; a trailing second word
        // has a zero opcode and costs one more idle cycle
        next_discard = 1'b1;
      end
      if (jump_taken) begin
        next_pc_load = 1'b1;
        next_discard = 1'b1;
        if (is_jump_reg) begin
          rel = rel + {6'h00, work[dst_sel], 1'b0};
        end else begin
          rel = rel + {{6{instr_word[15]}}, instr_word[15:0], 1'b0};
        end
        next_pc_target = {rel[22:1], 1'b0};
      end
    end
  end

  // Memory write, redirect and discard registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      file_we <= 1'b0;
      file_byte <= 1'b0;
      file_addr <= 13'h0000;
      file_wdata <= 16'h0000;
      pc_load <= 1'b0;
      pc_target <= 23'h000000;
      discard <= 1'b0;
      work_rd_data <= 16'h0000;
    end else begin
      file_we <= next_file_we;
      file_byte <= next_file_byte;
      file_addr <= next_file_addr;
      file_wdata <= next_file_wdata;
      pc_load <= next_pc_load;
      pc_target <= next_pc_target;
      discard <= next_discard;
      work_rd_data <= next_rd_data;
    end
  end

  // Checks on sequencing and flag effects
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_nop_inert: assert property (
    exec && op7 == cabbe_pkg::OP_NOP |=> !file_we && !pc_load &&
      $stable(status_flags))
    else $error("zero opcode word had an effect");
  chk_skip_drop: assert property (
    exec && skip_now ##1 instr_valid |-> discard ##1 !file_we)
    else $error("skipped word was not dropped");
  chk_skip_free: assert property (
    exec && is_bit && kind == cabbe_pkg::BK_TSC && !bit_clear &&
      !discard |=> !discard)
    else $error("test with set bit caused a skip");
  chk_jump_taken: assert property (
    exec && is_jump && jump_taken |=> pc_load && discard)
    else $error("taken jump did not redirect");
  chk_jump_flags: assert property (
    exec && (is_jump || is_jump_reg) |=> $stable(status_flags) ##1
      !(pc_load && $past(pc_load)))
    else $error("jump changed flags or redirected twice");
  chk_reg_jump: assert property (
    exec && is_jump_reg |=> pc_load)
    else $error("computed jump did not redirect");
  chk_target_even: assert property (
    pc_load |-> pc_target[0] == 1'b0)
    else $error("odd program address");
  chk_bit_flags: assert property (
    exec && (is_bit || is_flag_wr) |=> $stable(status_flags))
    else $error("bit operation changed flags");
  chk_and_flags: assert property (
    exec && is_arith && (grp == cabbe_pkg::GRP_AND ||
      (grp == cabbe_pkg::GRP_SHIFT && form == cabbe_pkg::FORM_REG)) |=>
      $stable(status_flags[cabbe_pkg::FL_DC]) &&
      $stable(status_flags[cabbe_pkg::FL_C]) &&
      $stable(status_flags[cabbe_pkg::FL_OV]))
    else $error("AND or multi shift touched C, DC or OV");
  chk_zero_sticky: assert property (
    exec && is_arith && grp == cabbe_pkg::GRP_SUMC &&
      !status_flags[cabbe_pkg::FL_Z] |=> !status_flags[cabbe_pkg::FL_Z])
    else $error("carry sum set the zero flag");

  cov_skip: cover property (exec && skip_now ##1 instr_valid);
  cov_jump: cover property (exec && is_jump && jump_taken);
  cov_sumc: cover property (exec && is_arith &&
    grp == cabbe_pkg::GRP_SUMC);
  cov_shift: cover property (exec && is_arith &&
    grp == cabbe_pkg::GRP_SHIFT && form == cabbe_pkg::FORM_REG);

endmodule // cabbe_execute
`default_nettype wire

// ---- rtl/cabbe_pkg.sv ----
// Constants shared by the execute datapath and its adder/shifter unit
package cabbe_pkg;
  // Instruction word layout
  localparam int INSTR_W = 24;
  localparam int OPC_LSB = 16;
  localparam int SIZE_LSB = 14;
  localparam int DEST_BIT = 13;
  localparam int FADDR_W = 13;
  localparam int BASE_LSB = 10;
  localparam int LITSEL_BIT = 9;
  localparam int SRC_LSB = 4;
  localparam int L10_LSB = 4;
  localparam int BITPOS_LSB = 12;
  localparam int FLAGSEL_BIT = 15;
  localparam int SHADOW_BIT = 7;
  localparam int PC_W = 23;
  // Data size codes; double-word runs as word here
  localparam logic [1:0] SZ_WORD = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  // Opcodes, low seven bits; bit 7 is the shadow select
  localparam logic [6:0] OP_NOP = 7'h00;
  localparam logic [6:0] OP_FLAG_WR = 7'h18;
  localparam logic [6:0] OP_JUMP_REG = 7'h30;
  localparam logic [2:0] FAM_ARITH = 3'h0;
  localparam logic [3:0] FAM_BIT = 4'h2;
  localparam logic [2:0] FAM_JUMP = 3'h2;
  // Arithmetic groups and operand forms
  localparam logic [1:0] GRP_SUM = 2'h0;
  localparam logic [1:0] GRP_SUMC = 2'h1;
  localparam logic [1:0] GRP_AND = 2'h2;
  localparam logic [1:0] GRP_SHIFT = 2'h3;
  localparam logic [1:0] FORM_F = 2'h1;
  localparam logic [1:0] FORM_L10 = 2'h2;
  localparam logic [1:0] FORM_REG = 2'h3;
  // Bit operation kinds
  localparam logic [1:0] BK_SET = 2'h0;
  localparam logic [1:0] BK_CLR = 2'h1;
  localparam logic [1:0] BK_TOG = 2'h2;
  localparam logic [1:0] BK_TSC = 2'h3;
  // Jump condition codes
  localparam logic [3:0] CC_ALWAYS = 4'h0;
  localparam logic [3:0] CC_C = 4'h1;
  localparam logic [3:0] CC_NC = 4'h2;
  localparam logic [3:0] CC_N = 4'h3;
  localparam logic [3:0] CC_NN = 4'h4;
  localparam logic [3:0] CC_OV = 4'h5;
  localparam logic [3:0] CC_NOV = 4'h6;
  localparam logic [3:0] CC_Z = 4'h7;
  localparam logic [3:0] CC_NZ = 4'h8;
  localparam logic [3:0] CC_GT = 4'h9;
  localparam logic [3:0] CC_GE = 4'ha;
  localparam logic [3:0] CC_LT = 4'hb;
  localparam logic [3:0] CC_LE = 4'hc;
  localparam logic [3:0] CC_GTU = 4'hd;
  localparam logic [3:0] CC_LEU = 4'he;
  // Status flag positions and reset values
  localparam int FL_Z = 0;
  localparam int FL_OV = 1;
  localparam int FL_N = 2;
  localparam int FL_DC = 3;
  localparam int FL_C = 4;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [15:0] WORK_RST = 16'h0000;
  // Adder/shifter operations
  typedef enum logic [1:0] {ALU_SUM, ALU_AND, ALU_SHR1, ALU_SHRN}
    cabbe_alu_op_t;
endpackage

// ---- rtl/cabbe_alu_if.sv ----
// Operand and result bundle between the core and its adder/shifter
`timescale 1ns/100ps
`default_nettype none
interface cabbe_alu_if;
  logic [15:0] a; // First operand
  logic [15:0] b; // Second operand
  logic cin; // Carry in
  logic byte_mode; // Work on the low byte only
  logic [4:0] count; // Multi-position shift count
  cabbe_pkg::cabbe_alu_op_t op;
  logic [15:0] res; // Result, upper byte zero in byte mode
  logic c, dc, n, ov, z; // Raw flag results
  modport core (output a, b, cin, byte_mode, count, op,
    input res, c, dc, n, ov, z);
  modport unit (input a, b, cin, byte_mode, count, op,
    output res, c, dc, n, ov, z);
endinterface
`default_nettype wire

// ---- rtl/cabbe_alu.sv ----
// Combinational adder, AND and arithmetic right shifter
`timescale 1ns/100ps
`default_nettype none
module cabbe_alu (
  // Operand bundle
  cabbe_alu_if.unit bus
);

  // Sign bit for the active data size
  function automatic logic top_bit(input logic [15:0] v, input logic bm);
    return bm ? v[7] : v[15];
  endfunction

  // Result and raw flags; the core decides which flags land
  always_comb begin
    logic [16:0] sum_w;
    logic [8:0] sum_b;
    logic [4:0] sum_n;
    logic [15:0] sa;
    logic [15:0] r;
    r = 16'h0000;
    sum_w = {1'b0, bus.a} + {1'b0, bus.b} + 17'(bus.cin);
    sum_b = {1'b0, bus.a[7:0]} + {1'b0, bus.b[7:0]} + 9'(bus.cin);
    sum_n = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + 5'(bus.cin);
    // Byte mode sign-extends so shifts keep the byte's sign
    sa = bus.byte_mode ? {{8{bus.a[7]}}, bus.a[7:0]} : bus.a;
    bus.c = 1'b0;
    bus.dc = 1'b0;
    bus.ov = 1'b0;
    case (bus.op)
      cabbe_pkg::ALU_SUM: begin
        r = sum_w[15:0];
        bus.c = bus.byte_mode ? sum_b[8] : sum_w[16];
        // Nibble carry in byte mode, byte carry in word mode
        bus.dc = bus.byte_mode ? sum_n[4] : sum_b[8];
        bus.ov = (top_bit(bus.a, bus.byte_mode) ==
          top_bit(bus.b, bus.byte_mode)) &&
          (top_bit(r, bus.byte_mode) != top_bit(bus.a, bus.byte_mode));
      end
      cabbe_pkg::ALU_AND: begin
        r = bus.a & bus.b;
      end
      cabbe_pkg::ALU_SHR1: begin
        // Sign bit kept, bit 0 falls into carry
        r = 16'($signed(sa) >>> 1);
        bus.c = bus.a[0];
      end
      default: begin
        // Counts above the width leave only sign copies
        r = 16'($signed(sa) >>> bus.count);
      end
    endcase
    bus.res = bus.byte_mode ? {8'h00, r[7:0]} : r;
    bus.n = top_bit(r, bus.byte_mode);
    bus.z = bus.byte_mode ? (r[7:0] == 8'h00) : (r == 16'h0000);
  end

endmodule // cabbe_alu
`default_nettype wire

// ---- sim/cabbe_mem_model.sv ----
// Data memory model that stands beside the execute stage's file port
`timescale 1ns/100ps
`default_nettype none
module cabbe_mem_model (
  // Clock
  input wire logic clock,
  // Word on the instruction port
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  // Write port from the execute stage
  input wire logic file_we,
  input wire logic file_byte,
  input wire logic [12:0] file_addr,
  input wire logic [15:0] file_wdata,
  // Operand read data
  output logic [15:0] file_rdata
);
  logic [15:0] mem [8]; // Eight words, picked by address bits 3:1
  logic [12:0] rd_addr; // Byte address of the operand
  // Bit forms carry a word address, the others a byte address
  assign rd_addr = (instr_word[22:19] == 4'h2) ?
    {instr_word[11:0], 1'b0} : instr_word[12:0];
  // Off-cycle data is inverted so a stale read never passes
  assign file_rdata = instr_valid ? mem[rd_addr[3:1]] :
    ~mem[rd_addr[3:1]];
  // Preload one negative word at the top of the address range
  initial begin
    mem = '{default: 16'h0000};
    mem[7] = 16'h8000;
  end
  // Writes land at the edge; a byte write keeps the upper byte
  always @(posedge clock) begin
    if (file_we) begin
      mem[file_addr[3:1]] <= file_byte ?
        {mem[file_addr[3:1]][15:8], file_wdata[7:0]} : file_wdata;
    end
  end
endmodule // cabbe_mem_model
`default_nettype wire

// ---- sim/cabbe_execute_tb.sv ----
// Self-checking bench for the execute stage
`timescale 1ns/100ps
`default_nettype none
module cabbe_execute_tb;
  logic clock, sys_rst, instr_valid, file_we, file_byte, pc_load, discard;
  logic [23:0] instr_word;
  logic [22:0] instr_pc, pc_target, pc, jp;
  logic [15:0] file_rdata, work_rd_data, file_wdata;
  logic [3:0] work_rd_sel;
  logic [12:0] file_addr;
  logic [4:0] status_flags, shadow_flags;
  logic [15:0] taken = 16'h594d; // Jump outcomes with only N set
  logic [23:0] bw [3] = '{24'h11f001, 24'h130001, 24'h151001};
  logic [15:0] be [3] = '{16'h83ff, 16'h83fe, 16'h83fc};
  int fails, n_compared;
  // 50 MHz clock
  always #10 clock = ~clock;
  cabbe_execute dut_u (.clock(clock), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .file_rdata(file_rdata),
    .work_rd_sel(work_rd_sel), .work_rd_data(work_rd_data),
    .file_we(file_we), .file_byte(file_byte), .file_addr(file_addr),
    .file_wdata(file_wdata), .pc_load(pc_load), .pc_target(pc_target),
    .discard(discard), .status_flags(status_flags),
    .shadow_flags(shadow_flags));
  cabbe_mem_model mem_u (.clock(clock), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_we(file_we), .file_byte(file_byte),
    .file_addr(file_addr), .file_wdata(file_wdata),
    .file_rdata(file_rdata));
  // Compare one value; four-state so unknowns never match
  task chk(input string nm, input logic [22:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Present one word at the falling edge; held until the next call
  task op(input logic [23:0] w);
    @(negedge clock);
    instr_valid = 1'b1;
    instr_word = w;
    instr_pc = pc;
    pc = pc + 23'h2;
  endtask
  // Drop valid; effects of the last word are settled here
  task idle;
    @(negedge clock);
    instr_valid = 1'b0;
  endtask
  // Observe a working register, one cycle of latency
  task rdw(input logic [3:0] s, input logic [15:0] e);
    @(negedge clock);
    work_rd_sel = s;
    @(negedge clock);
    chk("work", work_rd_data, e);
  endtask
  // Verdict and end of run
  task conclude;
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 24'h000000;
    instr_pc = 23'h000000;
    work_rd_sel = 4'h0;
    pc = 23'h000100;
    fails = 0;
    n_compared = 0;
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    chk("flags", status_flags, 5'h00);
    rdw(4'h1, 16'h0000);
    // Literal sums, then register sum with digit carry out of bit 7
    op({8'h02, 2'h0, 10'h3ff, 4'h1});
    op({8'h02, 2'h1, 10'h0ff, 4'h2});
    op({8'h03, 2'h0, 4'h1, 1'b0, 5'h02, 4'h3});
    idle;
    chk("flags", status_flags, 5'h08);
    // Byte sum with five-bit literal wraps to zero
    op({8'h03, 2'h1, 4'h2, 1'b1, 5'h01, 4'h4});
    idle;
    chk("flags", status_flags, 5'h19);
    rdw(4'h1, 16'h03ff);
    rdw(4'h3, 16'h04fe);
    rdw(4'h4, 16'h0000);
    // Carry sums: nonzero clears zero, a zero result keeps it clear
    for (int i = 0; i < 2; i++) begin
      op({8'h07, 2'h0, 4'h7, 1'b0, 5'h07, 4'h6});
      idle;
      chk("flags", status_flags, 5'h00);
    end
    // File forms at the top address: to accumulator, then to file
    op({8'h01, 2'h0, 1'b0, 13'h1ffe});
    op({8'h81, 2'h0, 1'b1, 13'h1ffe});
    idle;
    chk("we", file_we, 1'b1);
    chk("addr", file_addr, 13'h1ffe);
    chk("byte", file_byte, 1'b0);
    chk("wdata", file_wdata, 16'h0000);
    chk("flags", status_flags, 5'h13);
    chk("shadow", shadow_flags, 5'h13);
    idle;
    chk("we", file_we, 1'b0);
    rdw(4'h0, 16'h8000);
    // AND touches only N and Z
    op({8'h0b, 2'h0, 4'h0, 1'b0, 5'h00, 4'h8});
    idle;
    chk("flags", status_flags, 5'h16);
    // Single and multi-position shifts keep the sign
    op({8'h0e, 2'h0, 6'h00, 4'h8, 4'h9});
    idle;
    chk("flags", status_flags, 5'h04);
    op({8'h0f, 2'h0, 4'h8, 1'b1, 5'h0f, 4'ha});
    idle;
    rdw(4'h9, 16'hc000);
    rdw(4'ha, 16'hffff);
    // Every condition code, with a filler word after each
    for (int cc = 0; cc < 16; cc++) begin
      jp = pc;
      op({4'h2, cc[3:0], 16'h0003});
      idle;
      chk("load", pc_load, taken[cc]);
      chk("discard", discard, taken[cc]);
      if (taken[cc]) begin
        chk("target", pc_target, jp + 23'h8);
      end
      op(24'h00abcd);
      idle;
      chk("discard", discard, 1'b0);
    end
    // Computed jump through a register
    jp = pc;
    op({8'h30, 12'h000, 4'h2});
    idle;
    chk("load", pc_load, 1'b1);
    chk("target", pc_target, jp + 23'h200);
    op(24'h000000);
    // Set, clear and toggle on a register
    for (int k = 0; k < 3; k++) begin
      op(bw[k]);
      idle;
      rdw(4'h1, be[k]);
    end
    // Copy the zero flag into bit 0 of a register
    op({8'h18, 1'b1, 1'b0, 4'h8, 2'h0, 4'ha, 4'h0});
    idle;
    rdw(4'ha, 16'hfffe);
    chk("flags", status_flags, 5'h04);
    // Test-skip over a two-word pair: first dropped, second no-op
    op({8'h17, 4'h0, 8'h00, 4'h1});
    op({8'h02, 2'h0, 10'h001, 4'h1});
    chk("discard", discard, 1'b1);
    op(24'h00ffff);
    chk("discard", discard, 1'b0);
    idle;
    rdw(4'h1, 16'h83fc);
    op({8'h17, 4'hf, 8'h00, 4'h1});
    idle;
    chk("discard", discard, 1'b0);
    conclude;
  end
endmodule // cabbe_execute_tb
`default_nettype wire
